// *** gpoc_defines.vh ***
// register offsets, reset values and sizing constants for the gpio output control block
// Operation
// [RQ1] output enable write sets, output disable write clears driver status bits
// [RQ2] a line with driver status zero is input only, driver off
// [RQ3] a line with driver status one is driven when the port controller owns it
// [RQ4] set and clear output writes set and clear the output level bits
// [RQ5] enable and disable writes act regardless of line ownership
// [RQ6] set and clear writes act regardless of line ownership
// [RQ7] output level register accepts a direct single write
// [RQ8] direct write changes only bits whose write mask bit is one
// [RQ9] write mask enable write sets write mask status bits
// [RQ10] write mask disable write clears write mask status bits
// [RQ11] write mask status resets to zero
// [RQ12] open drain line is only driven low, released otherwise
// [RQ13] open drain enable and disable writes set and clear the selection
// [RQ14] open drain selection works under either line owner
// [RQ15] open drain status is readable per line
// [RQ16] open drain status resets to zero
// [RQ17] pin level status reflects synchronised actual pin level
`ifndef GPOC_DEFINES_VH
`define GPOC_DEFINES_VH

`define GPOC_ADDR_W             6
`define GPOC_OFS_OUT_EN         6'h00
`define GPOC_OFS_OUT_DIS        6'h04
`define GPOC_OFS_DRV_STAT       6'h08
`define GPOC_OFS_SET_OUT        6'h0C
`define GPOC_OFS_CLR_OUT        6'h10
`define GPOC_OFS_OUT_LEVEL      6'h14
`define GPOC_OFS_PIN_LEVEL      6'h18
`define GPOC_OFS_WMASK_EN       6'h1C
`define GPOC_OFS_WMASK_DIS      6'h20
`define GPOC_OFS_WMASK_STAT     6'h24
`define GPOC_OFS_OD_EN          6'h28
`define GPOC_OFS_OD_DIS         6'h2C
`define GPOC_OFS_OD_STAT        6'h30
`define GPOC_OFS_OWNER          6'h34

`define GPOC_RST_DRV_STAT       32'h00000000
`define GPOC_RST_OUT_LEVEL      32'h00000000
`define GPOC_RST_WMASK          32'h00000000
`define GPOC_RST_OD             32'h00000000
`define GPOC_RST_OWNER          32'h00000000

`define GPOC_UNMAPPED_READ      32'h00000000
`define GPOC_SYNC_STAGES        3

`endif

// *** gpoc_sync.v ***
// three-stage pin synchroniser with agreement filter for one input line
`timescale 1ns/1ps
`include "gpoc_defines.vh"

module gpoc_sync (
    // clock and reset
    input  wire clk,
    input  wire reset_n,
    // raw pin and filtered level
    input  wire pin_in,
    output reg  level_r
);

    reg meta_r;
    reg s2_r;
    reg s3_r;

    // only s2 reads meta; level moves when s2 and s3 agree
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r  <= 1'b0;
            s2_r    <= 1'b0;
            s3_r    <= 1'b0;
            level_r <= 1'b0;
        end else begin
            meta_r <= pin_in;
            s2_r   <= meta_r;
            s3_r   <= s2_r;
            if (s2_r == s3_r) begin
                level_r <= s3_r;
            end
        end
    end

endmodule

// *** gpoc_top.v ***
// gpio output control: avalon-mm register file, pad drive logic and pin feedback
//
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "gpoc_defines.vh"

module gpoc_top #(
    parameter LINES = 32
) (
    // clock and reset
    input  wire                    clk,
    input  wire                    reset_n,
    // avalon-mm slave
    input  wire [`GPOC_ADDR_W-1:0] avs_address,
    input  wire                    avs_read,
    input  wire                    avs_write,
    input  wire [31:0]             avs_writedata,
    input  wire [3:0]              avs_byteenable,
    output reg  [31:0]             avs_readdata,
    output wire                    avs_waitrequest,
    // peripheral function side of each line
    input  wire [LINES-1:0]        periph_out,
    input  wire [LINES-1:0]        periph_oe,
    // pads, three signals per two-way line
    input  wire [LINES-1:0]        pad_in,
    output reg  [LINES-1:0]        pad_out,
    output reg  [LINES-1:0]        pad_oe
);

    // stored state
    reg  [LINES-1:0] drv_stat_r;
    reg  [LINES-1:0] out_level_r;
    reg  [LINES-1:0] wmask_r;
    reg  [LINES-1:0] od_r;
    reg  [LINES-1:0] owner_r;     // one: port controller owns the line
    reg              ack_r;
    wire [LINES-1:0] pin_level;

    // byte-lane expanded write data; unselected lanes count as zero bits
    wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                           {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [31:0] wd_masked = avs_writedata & be_mask;
    wire [LINES-1:0] wbits = wd_masked[LINES-1:0];
    wire [LINES-1:0] wlane = be_mask[LINES-1:0];

    // one wait cycle per access: the request is taken when ack_r is high
    wire take = (avs_read | avs_write) & ack_r;
    wire wr   = avs_write & ack_r;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

    // wait-state generator; ack drops after each completed access
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read | avs_write) & ~ack_r;
        end
    end

    // address strobes for each command register
    wire hit_oen  = wr && (avs_address == `GPOC_OFS_OUT_EN);
    wire hit_odis = wr && (avs_address == `GPOC_OFS_OUT_DIS);
    wire hit_set  = wr && (avs_address == `GPOC_OFS_SET_OUT);
    wire hit_clr  = wr && (avs_address == `GPOC_OFS_CLR_OUT);
    wire hit_lvl  = wr && (avs_address == `GPOC_OFS_OUT_LEVEL);
    wire hit_wen  = wr && (avs_address == `GPOC_OFS_WMASK_EN);
    wire hit_wdis = wr && (avs_address == `GPOC_OFS_WMASK_DIS);
    wire hit_oden = wr && (avs_address == `GPOC_OFS_OD_EN);
    wire hit_oddi = wr && (avs_address == `GPOC_OFS_OD_DIS);
    wire hit_own  = wr && (avs_address == `GPOC_OFS_OWNER);

    // driver status update, independent of owner
    // [RQ1] [RQ5] enable sets disable clears
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            drv_stat_r <= `GPOC_RST_DRV_STAT;
        end else if (hit_oen) begin
            drv_stat_r <= drv_stat_r | wbits;
        end else if (hit_odis) begin
            drv_stat_r <= drv_stat_r & ~wbits;
        end
    end

    // output level: set, clear, or masked direct write
    // [RQ4] [RQ6] set clear level
    // [RQ7] [RQ8] masked direct write
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            out_level_r <= `GPOC_RST_OUT_LEVEL;
        end else if (hit_set) begin
            out_level_r <= out_level_r | wbits;
        end else if (hit_clr) begin
            out_level_r <= out_level_r & ~wbits;
        end else if (hit_lvl) begin
            out_level_r <= (out_level_r & ~(wmask_r & wlane)) |
                           (avs_writedata[LINES-1:0] & wmask_r & wlane);
        end
    end

    // write mask status
    // [RQ9] [RQ10] [RQ11] mask set clear reset
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wmask_r <= `GPOC_RST_WMASK;
        end else if (hit_wen) begin
            wmask_r <= wmask_r | wbits;
        end else if (hit_wdis) begin
            wmask_r <= wmask_r & ~wbits;
        end
    end

    // open drain selection, usable whichever party owns the line
    // [RQ13] [RQ14] [RQ16] od set clear
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            od_r <= `GPOC_RST_OD;
        end else if (hit_oden) begin
            od_r <= od_r | wbits;
        end else if (hit_oddi) begin
            od_r <= od_r & ~wbits;
        end
    end

    // line ownership is a plain read/write register, byte lanes honoured
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            owner_r <= `GPOC_RST_OWNER;
        end else if (hit_own) begin
            owner_r <= (owner_r & ~wlane) | (avs_writedata[LINES-1:0] & wlane);
        end
    end

    // pad drive per line; registered so pad outputs come from flip-flops
    genvar i;
    generate
        for (i = 0; i < LINES; i = i + 1) begin : g_line
            wire lvl = owner_r[i] ? out_level_r[i] : periph_out[i];
            wire en  = owner_r[i] ? drv_stat_r[i] : periph_oe[i];

            // [RQ2] [RQ3] drive per status
            // [RQ12] open drain drives low only
            always @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    pad_out[i] <= 1'b0;
                    pad_oe[i]  <= 1'b0;
                end else if (od_r[i]) begin
                    pad_out[i] <= 1'b0;
                    pad_oe[i]  <= en & ~lvl;
                end else begin
                    pad_out[i] <= lvl;
                    pad_oe[i]  <= en;
                end
            end

            // [RQ17] pin feedback sync
            gpoc_sync u_sync (
                .clk     (clk),
                .reset_n (reset_n),
                .pin_in  (pad_in[i]),
                .level_r (pin_level[i])
            );
        end
    endgenerate

    // read mux; registered at the edge that ends the wait cycle, unmapped reads return zero
    // [RQ15] od status readable
    reg [31:0] rd_nxt;
    always @* begin
        rd_nxt = `GPOC_UNMAPPED_READ;
        if (avs_address == `GPOC_OFS_DRV_STAT) begin
            rd_nxt[LINES-1:0] = drv_stat_r;
        end else if (avs_address == `GPOC_OFS_OUT_LEVEL) begin
            rd_nxt[LINES-1:0] = out_level_r;
        end else if (avs_address == `GPOC_OFS_PIN_LEVEL) begin
            rd_nxt[LINES-1:0] = pin_level;
        end else if (avs_address == `GPOC_OFS_WMASK_STAT) begin
            rd_nxt[LINES-1:0] = wmask_r;
        end else if (avs_address == `GPOC_OFS_OD_STAT) begin
            rd_nxt[LINES-1:0] = od_r;
        end else if (avs_address == `GPOC_OFS_OWNER) begin
            rd_nxt[LINES-1:0] = owner_r;
        end
    end

    // readdata loaded during the wait cycle, so it stands at the accept edge
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read & ~ack_r) begin
            avs_readdata <= rd_nxt;
        end
    end

endmodule

// *** gpoc_chk.sv ***
// assertion checker for the gpio output control block
`timescale 1ns/1ps
`include "gpoc_defines.vh"
module gpoc_chk #(parameter LINES = 32) (
    // clock and reset
    input wire             clk,
    input wire             reset_n,
    // avalon-mm slave
    input wire [5:0]       avs_address,
    input wire             avs_read,
    input wire             avs_write,
    input wire [31:0]      avs_writedata,
    input wire [3:0]       avs_byteenable,
    input wire [31:0]      avs_readdata,
    input wire             avs_waitrequest,
    // peripheral side and pads
    input wire [LINES-1:0] periph_out,
    input wire [LINES-1:0] periph_oe,
    input wire [LINES-1:0] pad_in,
    input wire [LINES-1:0] pad_out,
    input wire [LINES-1:0] pad_oe
);
    // disabled byte lanes count as zero bits
    wire [31:0] be_m = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [LINES-1:0] wd = avs_writedata[LINES-1:0] & be_m[LINES-1:0];
    reg  [LINES-1:0] drv_r, lvl_r, wm_r, od_r, own_r;
    // shadow registers, updated at the edge that accepts a write
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {drv_r, lvl_r, wm_r, od_r, own_r} <= {5*LINES{1'b0}};
        end else if (avs_write && !avs_waitrequest) begin
            case (avs_address)
                `GPOC_OFS_OUT_EN:    drv_r <= drv_r | wd;
                `GPOC_OFS_OUT_DIS:   drv_r <= drv_r & ~wd;
                `GPOC_OFS_SET_OUT:   lvl_r <= lvl_r | wd;
                `GPOC_OFS_CLR_OUT:   lvl_r <= lvl_r & ~wd;
                `GPOC_OFS_OUT_LEVEL: lvl_r <= (lvl_r & ~(wm_r & be_m[LINES-1:0])) | (wd & wm_r);
                `GPOC_OFS_WMASK_EN:  wm_r <= wm_r | wd;
                `GPOC_OFS_WMASK_DIS: wm_r <= wm_r & ~wd;
                `GPOC_OFS_OD_EN:     od_r <= od_r | wd;
                `GPOC_OFS_OD_DIS:    od_r <= od_r & ~wd;
                `GPOC_OFS_OWNER:     own_r <= (own_r & ~be_m[LINES-1:0]) | wd;
                default:             own_r <= own_r;
            endcase
        end
    end
    // open-drain lines only ever pull low, whoever owns them
    wire [LINES-1:0] en = (own_r & drv_r) | (~own_r & periph_oe);
    wire [LINES-1:0] lv = (own_r & lvl_r) | (~own_r & periph_out);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_rd(a);
        avs_read && !avs_waitrequest && avs_address == a;
    endsequence
    property p_back(a, v);
        s_rd(a) |-> avs_readdata == 32'(v);
    endproperty
    chk_wait_first: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("no answer after one wait state");
    chk_idle_free: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("wait raised while idle");
    chk_pad_oe: assert property (pad_oe == $past(en & ~(od_r & lv)))
        else $error("pad enable wrong");
    chk_pad_level: assert property (pad_out == $past(lv & ~od_r))
        else $error("pad level wrong");
    chk_drv_back: assert property (p_back(`GPOC_OFS_DRV_STAT, drv_r))
        else $error("driver status readback wrong");
    chk_level_back: assert property (p_back(`GPOC_OFS_OUT_LEVEL, lvl_r))
        else $error("level readback wrong");
    chk_mask_back: assert property (p_back(`GPOC_OFS_WMASK_STAT, wm_r))
        else $error("mask readback wrong");
    chk_od_back: assert property (p_back(`GPOC_OFS_OD_STAT, od_r))
        else $error("open drain readback wrong");
endmodule
bind gpoc_top gpoc_chk #(.LINES(LINES)) u_chk (.clk(clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .periph_out(periph_out), .periph_oe(periph_oe), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe));

// *** gpoc_pins.sv ***
// pin model: pull-up on every line plus external drivers that only pull low
`timescale 1ns/1ps
module gpoc_pins #(parameter LINES = 32) (
    // pad side of the block
    input  wire [LINES-1:0] pad_out,
    input  wire [LINES-1:0] pad_oe,
    // external drivers, one per line
    input  wire [LINES-1:0] ext_low,
    // resolved level
    output wire [LINES-1:0] pad_in
);
    // released lines rise through the pull-up; a low always wins
    assign pad_in = ~ext_low & (~pad_oe | pad_out);
endmodule

// *** tb_top.sv ***
// self-checking bench for the gpio output control block
`timescale 1ns/1ps
`include "gpoc_defines.vh"
module tb_top;
    reg         clk = 1'b0;
    reg         reset_n = 1'b0;
    reg  [5:0]  adr = 6'h00;
    reg         rd_en = 1'b0;
    reg         wr_en = 1'b0;
    reg  [31:0] wdat = 32'h00000000;
    reg  [3:0]  ben = 4'hF;
    reg  [31:0] p_out = 32'h00000000;
    reg  [31:0] p_oe = 32'h00000000;
    reg  [31:0] ext_low = 32'h00000000;
    reg  [31:0] q;
    wire [31:0] rdat, pin, pout, poe;
    wire        wreq;
    integer     bad_count = 0;
    integer     n_checks = 0;
    gpoc_top dut (.clk(clk), .reset_n(reset_n), .avs_address(adr), .avs_read(rd_en),
        .avs_write(wr_en), .avs_writedata(wdat), .avs_byteenable(ben), .avs_readdata(rdat),
        .avs_waitrequest(wreq), .periph_out(p_out), .periph_oe(p_oe), .pad_in(pin),
        .pad_out(pout), .pad_oe(poe));
    gpoc_pins pins (.pad_out(pout), .pad_oe(poe), .ext_low(ext_low), .pad_in(pin));
    initial begin
        forever #2 clk = ~clk;
    end
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("unexpected at %0t: got %h want %h", $time, seen, exp);
            end
        end
    endtask
    // one bus access, entered just after an edge; an idle edge follows the release
    // no wait limit here: only the watchdog ends a hung access
    task acc(input w, input [5:0] a, input [31:0] d);
        begin
            rd_en <= !w;
            wr_en <= w;
            adr <= a;
            wdat <= d;
            @(posedge clk);
            while (wreq !== 1'b0) begin
                @(posedge clk);
            end
            q = rdat;
            rd_en <= 1'b0;
            wr_en <= 1'b0;
            @(posedge clk);
        end
    endtask
    task wr(input [5:0] a, input [31:0] d);
        acc(1'b1, a, d);
    endtask
    task rdc(input [5:0] a, input [31:0] e);
        begin
            acc(1'b0, a, 32'h00000000);
            chk(q, e);
        end
    endtask
    // pads follow the registers one edge later
    task pads(input [31:0] e_oe, input [31:0] e_out);
        begin
            @(posedge clk);
            chk(poe, e_oe);
            chk(pout, e_out);
        end
    endtask
    task t_reset;
        begin
            rdc(`GPOC_OFS_DRV_STAT, 32'h00000000);
            rdc(`GPOC_OFS_WMASK_STAT, 32'h00000000);
            rdc(`GPOC_OFS_OD_STAT, 32'h00000000);
            rdc(6'h3C, `GPOC_UNMAPPED_READ);
        end
    endtask
    // commands land while the peripheral owns the lines
    task t_prepare;
        begin
            p_oe <= 32'h00001234;
            p_out <= 32'h00001200;
            wr(`GPOC_OFS_OUT_EN, 32'hA5A5A5A5);
            wr(`GPOC_OFS_OUT_DIS, 32'h0000FFFF);
            wr(`GPOC_OFS_SET_OUT, 32'hF0F0F0F0);
            wr(`GPOC_OFS_CLR_OUT, 32'h00F000F0);
            pads(32'h00001234, 32'h00001200);
            rdc(`GPOC_OFS_DRV_STAT, 32'hA5A50000);
            rdc(`GPOC_OFS_OUT_LEVEL, 32'hF000F000);
            wr(`GPOC_OFS_OWNER, 32'hFFFFFFFF);
            pads(32'hA5A50000, 32'hF000F000);
        end
    endtask
    task t_mask;
        begin
            wr(`GPOC_OFS_OUT_LEVEL, 32'hFFFFFFFF);
            rdc(`GPOC_OFS_OUT_LEVEL, 32'hF000F000);
            wr(`GPOC_OFS_WMASK_EN, 32'h000000FF);
            wr(`GPOC_OFS_WMASK_DIS, 32'h0000000F);
            wr(`GPOC_OFS_WMASK_STAT, 32'hFFFFFFFF);
            rdc(`GPOC_OFS_WMASK_STAT, 32'h000000F0);
            wr(`GPOC_OFS_OUT_LEVEL, 32'h00000050);
            rdc(`GPOC_OFS_OUT_LEVEL, 32'hF000F050);
            // raise two masked lines and lower two others in one access
            wr(`GPOC_OFS_OUT_LEVEL, 32'h000000A0);
            rdc(`GPOC_OFS_OUT_LEVEL, 32'hF000F0A0);
            // set bits only in a disabled byte lane must change nothing
            ben <= 4'hE;
            wr(`GPOC_OFS_SET_OUT, 32'h0000000F);
            ben <= 4'hF;
            rdc(`GPOC_OFS_OUT_LEVEL, 32'hF000F0A0);
        end
    endtask
    task t_open_drain;
        begin
            ext_low <= 32'h00000001;
            wr(`GPOC_OFS_OD_EN, 32'hFFFF00FF);
            wr(`GPOC_OFS_OD_DIS, 32'h0F000000);
            rdc(`GPOC_OFS_OD_STAT, 32'hF0FF00FF);
            pads(32'h05A50000, 32'h0000F000);
            repeat (6) @(posedge clk);
            rdc(`GPOC_OFS_PIN_LEVEL, 32'hFA5AFFFE);
            p_oe <= 32'h000000FF;
            p_out <= 32'h0000000F;
            wr(`GPOC_OFS_OWNER, 32'h00000000);
            pads(32'h000000F0, 32'h00000000);
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", n_checks, bad_count);
            if (bad_count == 0 && n_checks > 0) begin
                $display("Simulation passed");
            end else begin
                $display("Simulation failed");
            end
            $finish;
        end
    endtask
    // a full run needs about 100 cycles
    initial begin
        #20000;
        bad_count = bad_count + 1;
        tally_and_finish;
    end
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        t_reset;
        t_prepare;
        t_mask;
        t_open_drain;
        tally_and_finish;
    end
endmodule
